// [design/bit_synchroniser.sv]
/*
 * bit_synchroniser: two-flop synchroniser for one asynchronous level.
 * assumes: input comes from outside clk_sys; only the second flop is read.
 */
`timescale 1ns/100ps
module bit_synchroniser (
    input  wire logic clk_sys,  // system clock
    input  wire logic rst_b,    // async reset, active low
    input  wire logic asyncIn,  // raw level from a pin or analog block
    output logic      syncOut   // level safe to use in clk_sys
);
    logic stage1_ff; // metastability catcher, read only by stage two

    // plain two-stage chain, reset to zero
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            stage1_ff <= 1'b0;
            syncOut   <= 1'b0;
        end else begin
            stage1_ff <= asyncIn;
            syncOut   <= stage1_ff;
        end
    end
endmodule : bit_synchroniser

// [design/comparator_control_event.sv]
/*
 * comparator_control_event: digital control and status around one op amp /
 * comparator cell: the comparator_control word, result polarity, pin drive,
 * the sticky event flag, and an apb slave with a small interrupt block.
 * assumes: the analog cell gives one raw compare level per negative-input
 * channel plus one for the reference, all asynchronous to clk_sys.
 */
`timescale 1ns/100ps
module comparator_control_event (
    input  wire logic        clk_sys,     // system clock, 250 MHz
    input  wire logic        rst_b,       // async reset, active low
    input  wire logic        psel,        // apb select
    input  wire logic        penable,     // apb access phase
    input  wire logic        pwrite,      // apb direction, high = write
    input  wire logic [7:0]  paddr,       // apb byte address
    input  wire logic [31:0] pwdata,      // apb write data
    input  wire logic [3:0]  pstrb,       // apb byte strobes
    output logic             pready,      // apb ready, always one
    output logic [31:0]      prdata,      // apb read data
    output logic             pslverr,     // apb error on unmapped address
    input  wire logic [3:0]  chCompare,   // raw compare vs each minus channel
    input  wire logic        refCompare,  // raw compare vs internal reference
    output logic             circuitOn,   // analog cell power enable
    output logic             ampMode,     // analog cell in amplifier mode
    output logic [1:0]       chSelect,    // minus-input select to analog mux
    output logic             refSelect,   // reference select to analog mux
    output logic             resultPin,   // result_pin data
    output logic             resultPinOe_b, // result_pin enable, low drives
    output logic             eventTrigger, // one-cycle trigger to other blocks
    output logic             irq          // level interrupt
);
    // control word fields, one register each
    logic        enable_ff;     // circuit_enable
    logic        pinEn_ff;      // result_pin_enable
    logic        invert_ff;     // result_invert
    logic        amp_ff;        // amplifier_select
    logic        event_ff;      // event_flag
    logic [1:0]  edge_ff;       // event_edge_select
    logic        ref_ff;        // reference_select
    logic [1:0]  ch_ff;         // negative_input_select
    logic        result_ff;     // compare_result after polarity
    logic        resultPrev_ff; // result one cycle ago, for edge detect

    localparam int IRQ_W = comparator_control_pkg::IRQ_WIDTH; // status and enable width

    logic [IRQ_W-1:0] status_ff;  // sticky interrupt status
    logic [IRQ_W-1:0] irqEn_ff;   // interrupt enable
    logic [31:0] rdata_ff;      // registered read data
    logic        err_ff;        // registered slave error

    // synchronised analog levels
    logic [3:0]  chSync;        // per-channel compare, clk_sys domain
    logic        refSync;       // reference compare, clk_sys domain

    // combinational helpers
    logic        rawCompare;    // selected compare level before polarity
    logic        nxt_result;    // result after polarity
    logic        riseSeen;      // result went low to high
    logic        fallSeen;      // result went high to low
    logic        eventHit;      // qualified event this cycle
    logic        apbWrite;      // write access completes this cycle
    logic        apbRead;       // read access completes this cycle
    logic        ctrlWrite;     // write to comparator_control
    logic [15:0] ctrlWord;      // assembled control word for reads
    logic [15:0] wdata16;       // low half of write data after strobes
    logic        mapped;        // address decodes to a register

    // one synchroniser per minus channel, and one for the reference
    genvar gi;
    generate
        for (gi = 0; gi < comparator_control_pkg::NUM_CH; gi++) begin : gSync
            bit_synchroniser uSync (
                .clk_sys (clk_sys),
                .rst_b   (rst_b),
                .asyncIn (chCompare[gi]),
                .syncOut (chSync[gi])
            );
        end
    endgenerate

    bit_synchroniser uRefSync (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .asyncIn (refCompare),
        .syncOut (refSync)
    );

    // apb decode: zero-wait slave, so every access completes in its access phase
    assign pready   = 1'b1;
    assign apbWrite = psel && penable && pwrite;
    assign apbRead  = psel && penable && !pwrite;
    assign ctrlWrite = apbWrite && (paddr == comparator_control_pkg::ADDR_CONTROL);

    // strobes gate each byte of the 16-bit word; unstrobed bytes keep old value
    always_comb begin
        wdata16[7:0]  = pstrb[0] ? pwdata[7:0]  : ctrlWord[7:0];
        wdata16[15:8] = pstrb[1] ? pwdata[15:8] : ctrlWord[15:8];
    end

    always_comb begin
        unique case (paddr)
            comparator_control_pkg::ADDR_CONTROL,
            comparator_control_pkg::ADDR_STATUS,
            comparator_control_pkg::ADDR_IRQ_EN,
            comparator_control_pkg::ADDR_IRQ_CLR,
            comparator_control_pkg::ADDR_INPUT:  mapped = 1'b1;
            default:                             mapped = 1'b0;
        endcase
    end

    // input select: a missing channel reads as ground, i.e. compare low
    always_comb begin
        if (ref_ff) begin
            rawCompare = refSync;
        end else if (comparator_control_pkg::CH_PRESENT[ch_ff]) begin
            rawCompare = chSync[ch_ff];
        end else begin
            rawCompare = 1'b0;
        end
    end

    // polarity applies before report, pin and event logic; off cell reads zero
    always_comb begin
        if (!enable_ff || amp_ff) begin
            nxt_result = 1'b0; // comparator path idle when off or amplifying
        end else begin
            nxt_result = rawCompare ^ invert_ff;
        end
    end

    // edge qualification from the configured event_edge_select code
    assign riseSeen = result_ff && !resultPrev_ff;
    assign fallSeen = !result_ff && resultPrev_ff;

    always_comb begin
        unique case (edge_ff)
            comparator_control_pkg::EDGE_NONE: eventHit = 1'b0;
            comparator_control_pkg::EDGE_RISE: eventHit = riseSeen;
            comparator_control_pkg::EDGE_FALL: eventHit = fallSeen;
            comparator_control_pkg::EDGE_BOTH: eventHit = riseSeen || fallSeen;
        endcase
    end

    // result flops; reported and used by the edge detector
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            result_ff     <= 1'b0;
            resultPrev_ff <= 1'b0;
        end else begin
            result_ff     <= nxt_result;
            resultPrev_ff <= result_ff;
        end
    end

    // configuration fields: only implemented bits load
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            enable_ff <= 1'b0;
            pinEn_ff  <= 1'b0;
            invert_ff <= 1'b0;
            amp_ff    <= 1'b0;
            edge_ff   <= comparator_control_pkg::EDGE_NONE;
            ref_ff    <= 1'b0;
            ch_ff     <= 2'h0;
        end else if (ctrlWrite) begin
            enable_ff <= wdata16[comparator_control_pkg::BIT_ENABLE];
            pinEn_ff  <= wdata16[comparator_control_pkg::BIT_PIN_EN];
            invert_ff <= wdata16[comparator_control_pkg::BIT_INVERT];
            amp_ff    <= wdata16[comparator_control_pkg::BIT_AMP];
            edge_ff   <= wdata16[comparator_control_pkg::BIT_EDGE_HI:
                                 comparator_control_pkg::BIT_EDGE_LO];
            ref_ff    <= wdata16[comparator_control_pkg::BIT_REF];
            ch_ff     <= wdata16[comparator_control_pkg::BIT_CH_HI:
                                 comparator_control_pkg::BIT_CH_LO];
        end
    end

    // event flag: hardware set wins over a software clear in the same cycle;
    // writing one does not set it, so software cannot fake an event
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            event_ff <= 1'b0;
        end else if (eventHit && !event_ff) begin
            event_ff <= 1'b1;
        end else if (ctrlWrite && !wdata16[comparator_control_pkg::BIT_EVENT]) begin
            event_ff <= 1'b0;
        end
    end

    // trigger pulse only while the flag is clear
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            eventTrigger <= 1'b0;
        end else begin
            eventTrigger <= eventHit && !event_ff;
        end
    end

    // sticky status: set by an unblocked event, set beats write-one-to-clear
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            status_ff <= '0;
        end else begin
            for (int i = 0; i < IRQ_W; i++) begin
                if (i == comparator_control_pkg::IRQ_EVENT && eventHit && !event_ff) begin
                    status_ff[i] <= 1'b1;
                end else if (apbWrite && pwdata[i] && pstrb[0] &&
                             paddr == comparator_control_pkg::ADDR_IRQ_CLR) begin
                    status_ff[i] <= 1'b0;
                end
            end
        end
    end

    // interrupt enable register
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            irqEn_ff <= '0;
        end else if (apbWrite && pstrb[0] &&
                     paddr == comparator_control_pkg::ADDR_IRQ_EN) begin
            irqEn_ff <= pwdata[IRQ_W-1:0];
        end
    end

    assign irq = |(status_ff & irqEn_ff);

    // control word as read back; unimplemented bits are constant zero
    always_comb begin
        ctrlWord = comparator_control_pkg::WORD_ZERO;
        ctrlWord[comparator_control_pkg::BIT_ENABLE] = enable_ff;
        ctrlWord[comparator_control_pkg::BIT_PIN_EN] = pinEn_ff;
        ctrlWord[comparator_control_pkg::BIT_INVERT] = invert_ff;
        ctrlWord[comparator_control_pkg::BIT_AMP]    = amp_ff;
        ctrlWord[comparator_control_pkg::BIT_EVENT]  = event_ff;
        ctrlWord[comparator_control_pkg::BIT_RESULT] = result_ff;
        ctrlWord[comparator_control_pkg::BIT_EDGE_HI:
                 comparator_control_pkg::BIT_EDGE_LO] = edge_ff;
        ctrlWord[comparator_control_pkg::BIT_REF]    = ref_ff;
        ctrlWord[comparator_control_pkg::BIT_CH_HI:
                 comparator_control_pkg::BIT_CH_LO]  = ch_ff;
    end

    // read data sampled in the setup phase, so it is registered at access
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rdata_ff <= '0;
            err_ff   <= 1'b0;
        end else if (psel && !penable) begin
            err_ff   <= !mapped;
            rdata_ff <= '0;
            if (!pwrite) begin
                unique case (paddr)
                    comparator_control_pkg::ADDR_CONTROL: rdata_ff[15:0] <= ctrlWord;
                    comparator_control_pkg::ADDR_STATUS:  rdata_ff[IRQ_W-1:0] <= status_ff;
                    comparator_control_pkg::ADDR_IRQ_EN:  rdata_ff[IRQ_W-1:0] <= irqEn_ff;
                    comparator_control_pkg::ADDR_INPUT:   rdata_ff[4:0] <= {refSync, chSync};
                    default:                              rdata_ff <= '0;
                endcase
            end
        end
    end

    assign prdata  = rdata_ff;
    assign pslverr = err_ff && psel && penable;

    // analog controls come straight from the control flops
    assign circuitOn = enable_ff;
    assign ampMode   = amp_ff;
    assign chSelect  = ch_ff;
    assign refSelect = ref_ff;

    // pin drive: only in comparator mode with the pin enable set
    assign resultPin     = result_ff;
    assign resultPinOe_b = !(pinEn_ff && !amp_ff && enable_ff);

endmodule : comparator_control_event

// [design/comparator_control_pkg.sv]
/*
 * comparator_control_pkg: register map, field positions, reset values and the
 * event-selection codes shared by the comparator control block.
 * assumes: a 32-bit apb slave with one aligned word per register.
 */
package comparator_control_pkg;

    // register byte offsets on the apb bus
    localparam logic [7:0] ADDR_CONTROL  = 8'h00; // comparator_control word
    localparam logic [7:0] ADDR_STATUS   = 8'h04; // sticky interrupt status, read only
    localparam logic [7:0] ADDR_IRQ_EN   = 8'h08; // interrupt enable
    localparam logic [7:0] ADDR_IRQ_CLR  = 8'h0c; // write one to clear status
    localparam logic [7:0] ADDR_INPUT    = 8'h10; // raw analog sample, read only

    // comparator_control field positions
    localparam int BIT_ENABLE     = 15; // circuit_enable
    localparam int BIT_PIN_EN     = 14; // result_pin_enable
    localparam int BIT_INVERT     = 13; // result_invert
    localparam int BIT_AMP        = 10; // amplifier_select
    localparam int BIT_EVENT      = 9;  // event_flag
    localparam int BIT_RESULT     = 8;  // compare_result
    localparam int BIT_EDGE_HI    = 7;  // event_edge_select msb
    localparam int BIT_EDGE_LO    = 6;  // event_edge_select lsb
    localparam int BIT_REF        = 4;  // reference_select
    localparam int BIT_CH_HI      = 1;  // negative_input_select msb
    localparam int BIT_CH_LO      = 0;  // negative_input_select lsb

    // writable bits of the control word; 12, 11, 5, 3, 2 stay zero
    localparam logic [15:0] CONTROL_WMASK = 16'he6d3;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [15:0] WORD_ZERO     = 16'h0000;

    // event_edge_select codes
    localparam logic [1:0] EDGE_NONE = 2'h0; // events off
    localparam logic [1:0] EDGE_RISE = 2'h1; // low to high of result
    localparam logic [1:0] EDGE_FALL = 2'h2; // high to low of result
    localparam logic [1:0] EDGE_BOTH = 2'h3; // either transition

    // interrupt status bit positions
    localparam int IRQ_EVENT   = 0; // qualified comparator event
    localparam int IRQ_WIDTH   = 1;

    // number of negative-input choices and of the analog samples
    localparam int NUM_CH      = 4;
    localparam logic [3:0] CH_PRESENT = 4'h7; // bond mask: which channels exist

endpackage : comparator_control_pkg

// [verif/analog_cell_model.sv]
/*
 * analog_cell_model: stand-in for the comparator cell and its input pins.
 * assumes: the bench sets the wanted compare levels; clk_sys paces noise.
 */
`timescale 1ns/100ps
module analog_cell_model (
    input  wire logic       clk_sys,    // paces the noise pattern
    input  wire logic       circuitOn,  // cell powered
    input  wire logic [3:0] level,      // wanted compare, plus above minus
    input  wire logic       refLevel,   // wanted compare against reference
    output logic      [3:0] chCompare,  // raw compare per minus channel
    output logic            refCompare  // raw compare against reference
);
    logic noise_ff = 1'b0; // floating node: changes every cycle, never a clean level

    // free-running pattern so an undriven input cannot pass for a steady 0
    always_ff @(posedge clk_sys) begin
        noise_ff <= ~noise_ff;
    end

    // channel 3 has no pin here, so only noise reaches it
    assign chCompare[3] = noise_ff;
    // an unpowered cell gives no meaningful compare
    assign chCompare[2:0] = circuitOn ? level[2:0] : {3{noise_ff}};
    assign refCompare = circuitOn ? refLevel : noise_ff;
endmodule : analog_cell_model

// [verif/comparator_control_event_checker.sv]
/*
 * comparator_control_event_checker: port-level assertions for the block.
 * assumes: bound to comparator_control_event; sees only its top-level ports.
 */
`timescale 1ns/100ps
module comparator_control_event_checker (
    input wire logic        clk_sys,       // system clock
    input wire logic        rst_b,         // async reset, active low
    input wire logic        psel,          // apb select
    input wire logic        penable,       // apb access phase
    input wire logic        pwrite,        // apb direction
    input wire logic [7:0]  paddr,         // apb address
    input wire logic        pready,        // apb ready
    input wire logic [31:0] prdata,        // apb read data
    input wire logic        pslverr,       // apb error
    input wire logic        circuitOn,     // cell power
    input wire logic        ampMode,       // amplifier mode
    input wire logic        resultPin,     // result pin data
    input wire logic        resultPinOe_b, // result pin enable, low drives
    input wire logic        eventTrigger   // event pulse
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // an access to a hole in the map: misaligned or past the last register
    wire logic badAddr = (paddr > 8'h10) || (paddr[1:0] != 2'h0);

    a_amp_pin_off: assert property (ampMode |-> resultPinOe_b)
        else $error("pin driven in amplifier mode");
    a_off_pin_off: assert property (!circuitOn |-> resultPinOe_b)
        else $error("pin driven while circuit off");
    // three cycles allow for the result register catching up after disable
    a_off_result_low: assert property (!circuitOn [*3] |-> !resultPin)
        else $error("result high while circuit off");
    a_trig_once: assert property (eventTrigger |=> !eventTrigger)
        else $error("trigger repeated while flag set");
    // only a write can clear the flag, so without writes no trigger may follow;
    // a write in the trigger cycle itself could clear the flag, so it is excluded
    a_trig_blocked: assert property ((eventTrigger && !(psel && pwrite)) ##1 (!(psel && pwrite)) [*6]
        |=> !eventTrigger)
        else $error("trigger while event flag set");
    a_ready_access: assert property (psel && penable |-> pready)
        else $error("access phase without ready");
    a_err_unmapped: assert property (psel && penable && badAddr |-> pslverr)
        else $error("unmapped access without error");
    a_err_mapped: assert property (psel && penable && !badAddr |-> !pslverr)
        else $error("mapped access flagged as error");
    a_ctrl_reserved: assert property (psel && penable && !pwrite
        && paddr == comparator_control_pkg::ADDR_CONTROL
        |-> prdata[12:11] == 2'h0 && prdata[31:16] == 16'h0000)
        else $error("reserved control bits read non-zero");

    c_event: cover property (eventTrigger);
    c_pin_driven: cover property (!resultPinOe_b);
    c_error: cover property (psel && penable && pslverr);
endmodule : comparator_control_event_checker

bind comparator_control_event comparator_control_event_checker
    comparator_control_event_checker_i (.clk_sys, .rst_b, .psel, .penable, .pwrite,
    .paddr, .pready, .prdata, .pslverr, .circuitOn, .ampMode, .resultPin,
    .resultPinOe_b, .eventTrigger);

// [verif/tb_comparator_control_event.sv]
/*
 * tb_comparator_control_event: self-checking bench for the comparator block:
 * register access, pin routing, polarity and the sticky event flag.
 * assumes: design, checker and analog_cell_model are compiled before it.
 */
`timescale 1ns/100ps
module tb_comparator_control_event;
    localparam logic [7:0] CTL = comparator_control_pkg::ADDR_CONTROL; // control
    localparam logic [7:0] STA = comparator_control_pkg::ADDR_STATUS;  // status
    localparam logic [7:0] IEN = comparator_control_pkg::ADDR_IRQ_EN;  // irq enable
    localparam logic [7:0] ICL = comparator_control_pkg::ADDR_IRQ_CLR; // irq clear
    logic        clk_sys, rst_b;             // clock, reset active low
    logic        psel, penable, pwrite;      // apb control
    logic [7:0]  paddr;                      // apb address
    logic [31:0] pwdata, prdata, rdat;       // apb data, last read
    logic [3:0]  pstrb, chCompare, level;    // strobes, compares, wanted levels
    logic        pready, pslverr, rerr;      // apb answer, last error
    logic        refCompare, refLevel;       // reference compare
    logic        circuitOn, ampMode, refSelect, resultPin; // cell controls
    logic        resultPinOe_b, eventTrigger, irq;         // pin, event, interrupt
    logic [1:0]  chSelect;                   // minus-input select
    int          trigSeen, checks, mismatches; // counters

    comparator_control_event comparator_control_event_i (.clk_sys, .rst_b, .psel,
        .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr,
        .chCompare, .refCompare, .circuitOn, .ampMode, .chSelect, .refSelect,
        .resultPin, .resultPinOe_b, .eventTrigger, .irq);
    analog_cell_model analog_cell_model_i (.clk_sys, .circuitOn, .level, .refLevel,
        .chCompare, .refCompare);

    // free-running 250 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // one apb transfer; a spare edge first keeps psel from two assignments at once
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            mismatches++;
            conclude();
        end
    endtask : xfer

    // sample outputs mid-cycle, after the write edge has landed
    task automatic settle();
        @(negedge clk_sys);
    endtask : settle

    // 6 cycles cover 2 sync flops plus the result register
    task automatic readCtl();
        repeat (6) @(posedge clk_sys);
        xfer(1'b0, CTL, 32'h0);
    endtask : readCtl

    task automatic countTrig(input int n);
        trigSeen = 0;
        repeat (n) begin
            @(posedge clk_sys);
            if (eventTrigger === 1'b1) trigSeen++;
        end
    endtask : countTrig

    task automatic testRegs();
        xfer(1'b0, CTL, 32'h0);
        check("control reset", rdat, 32'h0);
        check("irq reset", irq, 1'b0);
        xfer(1'b1, CTL, 32'hffff_183c);
        xfer(1'b0, CTL, 32'h0);
        check("control reserved", rdat, 32'h0000_0010);
        check("circuit off", circuitOn, 1'b0);
        check("ref select", refSelect, 1'b1);
        xfer(1'b0, 8'h20, 32'h0);
        check("unmapped data", rdat, 32'h0);
        check("unmapped error", rerr, 1'b1);
        $display("test registers done");
    endtask : testRegs

    task automatic testOutputs();
        xfer(1'b1, CTL, 32'h0000_c002);
        settle();
        check("circuit on", circuitOn, 1'b1);
        check("channel select", chSelect, 2'h2);
        check("pin driven", resultPinOe_b, 1'b0);
        xfer(1'b1, CTL, 32'h0000_c402);
        settle();
        check("amp mode", ampMode, 1'b1);
        check("pin in amp mode", resultPinOe_b, 1'b1);
        xfer(1'b1, CTL, 32'h0000_8002);
        settle();
        check("pin internal", resultPinOe_b, 1'b1);
        $display("test outputs done");
    endtask : testOutputs

    task automatic testPolarity();
        xfer(1'b1, CTL, 32'h0000_c000);
        level <= 4'hf;
        readCtl();
        check("result plus high", rdat[8], 1'b1);
        check("pin level", resultPin, 1'b1);
        level <= 4'h0;
        readCtl();
        check("result plus low", rdat[8], 1'b0);
        xfer(1'b1, CTL, 32'h0000_e000);
        readCtl();
        check("inverted low", rdat[8], 1'b1);
        level <= 4'hf;
        readCtl();
        check("inverted high", rdat[8], 1'b0);
        xfer(1'b1, CTL, 32'h0000_8003);
        readCtl();
        check("missing channel", rdat[8], 1'b0);
        xfer(1'b1, CTL, 32'h0000_8010);
        refLevel <= 1'b1;
        readCtl();
        check("reference high", rdat[8], 1'b1);
        refLevel <= 1'b0;
        readCtl();
        check("reference low", rdat[8], 1'b0);
        $display("test polarity done");
    endtask : testPolarity

    task automatic testEvent();
        xfer(1'b1, CTL, 32'h0000_8000);
        level <= 4'h0;
        xfer(1'b1, IEN, 32'h1);
        readCtl();
        xfer(1'b1, CTL, 32'h0000_8040);
        level <= 4'h1;
        countTrig(20);
        check("first trigger", trigSeen, 1);
        xfer(1'b0, CTL, 32'h0);
        check("event flag", rdat[9], 1'b1);
        check("irq raised", irq, 1'b1);
        xfer(1'b1, ICL, 32'h1);
        settle();
        check("irq cleared", irq, 1'b0);
        xfer(1'b0, STA, 32'h0);
        check("status cleared", rdat, 32'h0);
        level <= 4'h0;
        readCtl();
        level <= 4'h1;
        countTrig(14);
        check("blocked trigger", trigSeen, 0);
        xfer(1'b0, STA, 32'h0);
        check("blocked status", rdat, 32'h0);
        xfer(1'b0, CTL, 32'h0);
        check("flag held", rdat[9], 1'b1);
        xfer(1'b1, CTL, 32'h0000_8040);
        readCtl();
        check("flag cleared", rdat[9], 1'b0);
        level <= 4'h0;
        readCtl();
        level <= 4'h1;
        countTrig(20);
        check("trigger again", trigSeen, 1);
        xfer(1'b1, CTL, 32'h0000_8080);
        level <= 4'h0;
        countTrig(20);
        check("falling trigger", trigSeen, 1);
        xfer(1'b1, CTL, 32'h0000_80c0);
        level <= 4'h1;
        countTrig(20);
        check("either trigger", trigSeen, 1);
        xfer(1'b1, IEN, 32'h0);
        settle();
        check("irq masked", irq, 1'b0);
        $display("test event done");
    endtask : testEvent

    // reset, then the scenarios in order
    initial begin
        checks = 0;
        mismatches = 0;
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hf;
        level = 4'h0;
        refLevel = 1'b0;
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        testRegs();
        testOutputs();
        testPolarity();
        testEvent();
        conclude();
    end
endmodule : tb_comparator_control_event
